// ### design/ldoc_consts.vh
// Offsets, field positions and reset values of the LDO control register bank
`ifndef LDOC_CONSTS_VH
`define LDOC_CONSTS_VH
`define LDOC_ADDR_LDO_FOUR  8'h6f
`define LDOC_ADDR_LDO_FIVE  8'h70
`define LDOC_ADDR_LDO_SIX   8'h71
`define LDOC_VSET_MSB       3
`define LDOC_VSET_LSB       0
`define LDOC_EN_BIT         4
`define LDOC_STBY_BIT       5
`define LDOC_LPWR_BIT       6
`define LDOC_CTL_WMASK      8'h7f
`define LDOC_CTL_RESET      8'h00
`define LDOC_NUM_LDO        3
`endif

// ### design/ldoc_regs.v
// LDO control register bank for three regulators, with short-circuit handling
`timescale 1ns/100ps
`include "ldoc_consts.vh"

module ldoc_regs (
	input  wire       ref_clk,        // 25 MHz clock
	input  wire       resetn,         // Async reset, active low
	input  wire       reg_wr,         // Register write strobe
	input  wire [7:0] reg_addr,       // Register byte address
	input  wire [7:0] reg_wdata,      // Write data
	output reg  [7:0] reg_rdata,      // Read data, one cycle after address
	input  wire       scp_enable,     // Short-circuit protection enable
	input  wire       standby_in,     // Chip standby condition, from a pin
	input  wire [2:0] short_det,      // Debounced short per regulator, from pins
	input  wire [2:0] fault_mask,     // Fault interrupt mask per regulator
	input  wire [2:0] fault_clr,      // Fault flag clear per regulator, pulse
	output reg  [3:0] ldo_four_voltage_setpoint, // Setpoint to regulator four
	output reg  [3:0] ldo_five_voltage_setpoint, // Setpoint to regulator five
	output reg  [3:0] ldo_six_voltage_setpoint,  // Setpoint to regulator six
	output reg  [2:0] ldo_out_on,     // Regulator output on, per regulator
	output reg  [2:0] ldo_out_lowpwr, // Regulator in low-power mode, per regulator
	output reg  [2:0] ldo_fault_interrupt_flag, // Sticky fault flags
	output reg        fault_irq       // Unmasked fault request
);

	// Reset release chain and its synchronised copy
	reg  [1:0] rst_sync_q;
	wire       rst_n;

	// Standby pin synchroniser and accepted level
	reg        stby_s1_q;
	reg        stby_s2_q;
	reg        stby_s3_q;
	reg        stby_q;

	// Short-detect synchronisers, accepted level and edge history
	reg  [2:0] sc_s1_q;
	reg  [2:0] sc_s2_q;
	reg  [2:0] sc_s3_q;
	reg  [2:0] sc_q;
	reg  [2:0] sc_prev_q;
	wire [2:0] sc_agree;
	wire [2:0] sc_rise;

	// Control bytes, one per regulator, addressed by index
	reg  [7:0] ctl_q [0:2];
	wire [1:0] acc_idx;

	// Next values of the registered outputs
	reg  [7:0] rdata_d;
	reg  [2:0] on_d;
	reg  [2:0] lowpwr_d;
	reg  [2:0] flag_d;

	// Loop indices, none shared by two processes so no variable has two drivers
	integer    ri;
	integer    wi;
	integer    oi;
	integer    fi;

	// Maps a bus address to a register index; 3 means unmapped
	function [1:0] ldoc_index;
		input [7:0] addr;
		begin
			case (addr)
				`LDOC_ADDR_LDO_FOUR: ldoc_index = 2'd0;
				`LDOC_ADDR_LDO_FIVE: ldoc_index = 2'd1;
				`LDOC_ADDR_LDO_SIX:  ldoc_index = 2'd2;
				default:             ldoc_index = 2'd3;
			endcase
		end
	endfunction

	// Output on: enable set, unless standby asks for off without low power
	function ldoc_out_on;
		input [7:0] ctl;
		input       stby;
		begin
			ldoc_out_on = ctl[`LDOC_EN_BIT] &
				~(ctl[`LDOC_STBY_BIT] & stby & ~ctl[`LDOC_LPWR_BIT]);
		end
	endfunction

	// Low power: enabled with the low-power bit, except standby-only use out of standby
	function ldoc_out_low;
		input [7:0] ctl;
		input       stby;
		begin
			ldoc_out_low = ctl[`LDOC_EN_BIT] & ctl[`LDOC_LPWR_BIT] &
				~(ctl[`LDOC_STBY_BIT] & ~stby);
		end
	endfunction

	// Reset asserts at once but leaves only on a clock edge
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			rst_sync_q <= 2'h0;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end
	assign rst_n = rst_sync_q[1];

	// One synchroniser serves all three regulators
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			stby_s1_q <= 1'b0;
			stby_s2_q <= 1'b0;
			stby_s3_q <= 1'b0;
			stby_q    <= 1'b0;
		end else begin
			stby_s1_q <= standby_in;
			stby_s2_q <= stby_s1_q;
			stby_s3_q <= stby_s2_q;
			// A change counts once stages two and three agree
			if (stby_s2_q == stby_s3_q)
				stby_q <= stby_s3_q;
		end
	end

	// Per-bit agreement filter keeps a single glitch from reaching the flags
	assign sc_agree = ~(sc_s2_q ^ sc_s3_q);

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sc_s1_q   <= 3'h0;
			sc_s2_q   <= 3'h0;
			sc_s3_q   <= 3'h0;
			sc_q      <= 3'h0;
			sc_prev_q <= 3'h0;
		end else begin
			sc_s1_q   <= short_det;
			sc_s2_q   <= sc_s1_q;
			sc_s3_q   <= sc_s2_q;
			sc_q      <= (sc_agree & sc_s3_q) | (~sc_agree & sc_q);
			sc_prev_q <= sc_q;
		end
	end
	assign sc_rise = sc_q & ~sc_prev_q;

	assign acc_idx = ldoc_index(reg_addr);

	// A short that coincides with a host write still disables the regulator
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (ri = 0; ri < 3; ri = ri + 1)
				ctl_q[ri] <= `LDOC_CTL_RESET;
		end else begin
			for (wi = 0; wi < 3; wi = wi + 1) begin
				if (reg_wr && acc_idx == wi[1:0])
					ctl_q[wi] <= reg_wdata & `LDOC_CTL_WMASK;
				if (sc_q[wi] && scp_enable)
					ctl_q[wi][`LDOC_EN_BIT] <= 1'b0;
			end
		end
	end

	// Read data of the addressed register; unmapped addresses read zero
	always @* begin
		case (acc_idx)
			2'd0:    rdata_d = ctl_q[0] & `LDOC_CTL_WMASK;
			2'd1:    rdata_d = ctl_q[1] & `LDOC_CTL_WMASK;
			2'd2:    rdata_d = ctl_q[2] & `LDOC_CTL_WMASK;
			default: rdata_d = 8'h00;
		endcase
	end

	// Output state of each regulator from its control byte and standby
	always @* begin
		on_d     = 3'h0;
		lowpwr_d = 3'h0;
		for (oi = 0; oi < 3; oi = oi + 1) begin
			on_d[oi]     = ldoc_out_on(ctl_q[oi], stby_q);
			lowpwr_d[oi] = ldoc_out_low(ctl_q[oi], stby_q);
		end
	end

	// Sticky flags; a new short wins over a clear in the same cycle
	always @* begin
		flag_d = ldo_fault_interrupt_flag;
		for (fi = 0; fi < 3; fi = fi + 1) begin
			if (sc_rise[fi])
				flag_d[fi] = 1'b1;
			else if (fault_clr[fi])
				flag_d[fi] = 1'b0;
		end
	end

	// Every output leaves straight from a flip-flop
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata                 <= 8'h00;
			ldo_four_voltage_setpoint <= 4'h0;
			ldo_five_voltage_setpoint <= 4'h0;
			ldo_six_voltage_setpoint  <= 4'h0;
			ldo_out_on                <= 3'h0;
			ldo_out_lowpwr            <= 3'h0;
			ldo_fault_interrupt_flag  <= 3'h0;
			fault_irq                 <= 1'b0;
		end else begin
			reg_rdata                 <= rdata_d;
			ldo_four_voltage_setpoint <= ctl_q[0][`LDOC_VSET_MSB:`LDOC_VSET_LSB];
			ldo_five_voltage_setpoint <= ctl_q[1][`LDOC_VSET_MSB:`LDOC_VSET_LSB];
			ldo_six_voltage_setpoint  <= ctl_q[2][`LDOC_VSET_MSB:`LDOC_VSET_LSB];
			ldo_out_on                <= on_d;
			ldo_out_lowpwr            <= lowpwr_d;
			ldo_fault_interrupt_flag  <= flag_d;
			// Raw edge included so the request does not wait for the flag
			fault_irq <= |((ldo_fault_interrupt_flag | sc_rise) & ~fault_mask);
		end
	end

endmodule

// ### tb/ldoc_checker.sv
// Port-level assertions for the LDO control register bank
`timescale 1ns/100ps
module ldoc_checker (
	input wire       ref_clk, resetn, reg_wr, scp_enable, fault_irq, // Clock, reset, strobes
	input wire [7:0] reg_addr, reg_wdata, reg_rdata,                 // Register port
	input wire [3:0] ldo_four_voltage_setpoint,                      // Setpoint four
	input wire [2:0] ldo_out_on, ldo_fault_interrupt_flag, fault_mask, fault_clr // Per LDO
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	wire       w4 = reg_wr && reg_addr == 8'h6f;
	wire       un = reg_addr < 8'h6f || reg_addr > 8'h71;
	wire [2:0] keep = ldo_fault_interrupt_flag & ~fault_clr;
	a_top_bit_zero: assert property (reg_rdata[7] == 1'b0) else $error("top bit set");
	a_unmapped_reads_zero: assert property (un |=> reg_rdata == 8'h00) else $error("unmapped");
	a_write_read_back: assert property (w4 ##1 !reg_wr && reg_addr == 8'h6f
		|=> (reg_rdata & 8'h6f) == ($past(reg_wdata, 2) & 8'h6f)) else $error("readback");
	a_setpoint_follows: assert property (w4 |-> ##2
		ldo_four_voltage_setpoint == $past(reg_wdata[3:0], 2)) else $error("setpoint");
	a_enable_drives_out: assert property (w4 && !scp_enable && !reg_wdata[5] |-> ##2
		ldo_out_on[0] == $past(reg_wdata[4], 2)) else $error("enable");
	a_irq_masked: assert property (fault_mask == 3'h7 ##1 fault_mask == 3'h7 |-> !fault_irq)
		else $error("masked irq");
	a_flag_stays_set: assert property (keep != 3'h0
		|=> (ldo_fault_interrupt_flag & $past(keep)) == $past(keep)) else $error("flag lost");
	a_scp_clears_out: assert property ($rose(ldo_fault_interrupt_flag[0]) && scp_enable
		|-> ##[1:3] !ldo_out_on[0]) else $error("no shutdown");
	c_scp: cover property ($rose(ldo_fault_interrupt_flag[0]) && scp_enable);
	c_irq: cover property ($rose(fault_irq));
	c_wr: cover property (w4 ##1 !reg_wr);
endmodule
bind ldoc_regs ldoc_checker i_chk(
	.ref_clk(ref_clk), .resetn(resetn), .reg_wr(reg_wr), .scp_enable(scp_enable),
	.fault_irq(fault_irq), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata), .ldo_four_voltage_setpoint(ldo_four_voltage_setpoint),
	.ldo_out_on(ldo_out_on), .ldo_fault_interrupt_flag(ldo_fault_interrupt_flag),
	.fault_mask(fault_mask), .fault_clr(fault_clr));

// ### tb/ldoc_host.sv
// Host model on the register port
`timescale 1ns/100ps
module ldoc_host (
	input wire       ref_clk,   // Clock
	output reg       reg_wr,    // Write strobe
	output reg [7:0] reg_addr,  // Address
	output reg [7:0] reg_wdata, // Write data
	output reg       rd_chk     // Read data due after next edge
);
	logic [7:0] exp_q[$];
	initial {reg_wr, reg_addr, reg_wdata, rd_chk} = 18'h0;
	task wr(input logic [7:0] a, d);
		@(negedge ref_clk) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
		@(negedge ref_clk) {reg_wr, reg_wdata} = {1'b0, ~d};
	endtask
	task rd(input logic [7:0] a, e);
		@(negedge ref_clk) {reg_addr, rd_chk} = {a, 1'b1};
		exp_q.push_back(e);
		@(negedge ref_clk) rd_chk = 1'b0;
	endtask
endmodule

// ### tb/testbench.sv
// Self-checking bench for the LDO control register bank
`timescale 1ns/100ps
module testbench;
	logic ref_clk = 0, resetn = 0, scp_enable = 0, standby_in = 0, fault_irq, reg_wr, rd_chk;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, r = 8'h3f, d[3];
	logic [2:0] short_det = 0, fault_mask = 0, fault_clr = 0, en, lp;
	logic [2:0] ldo_out_on, ldo_out_lowpwr, ldo_fault_interrupt_flag;
	logic [3:0] ldo_four_voltage_setpoint, ldo_five_voltage_setpoint, ldo_six_voltage_setpoint;
	int fail_count = 0, checks = 0;
	initial forever #20 ref_clk = ~ref_clk;
	ldoc_host i_host(.ref_clk(ref_clk), .reg_wr(reg_wr), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .rd_chk(rd_chk));
	ldoc_regs i_dut(
		.ref_clk(ref_clk), .resetn(resetn), .reg_wr(reg_wr), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .scp_enable(scp_enable),
		.standby_in(standby_in), .short_det(short_det), .fault_mask(fault_mask),
		.fault_clr(fault_clr), .ldo_four_voltage_setpoint(ldo_four_voltage_setpoint),
		.ldo_five_voltage_setpoint(ldo_five_voltage_setpoint),
		.ldo_six_voltage_setpoint(ldo_six_voltage_setpoint), .ldo_out_on(ldo_out_on),
		.ldo_out_lowpwr(ldo_out_lowpwr), .ldo_fault_interrupt_flag(ldo_fault_interrupt_flag),
		.fault_irq(fault_irq));
	task check(input string nm, input logic [11:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task final_report;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	always @(posedge ref_clk) if (rd_chk) #1 check("rdata", reg_rdata, i_host.exp_q.pop_front());
	initial begin #400000; fail_count++; final_report; end
	initial begin
		repeat (6) @(negedge ref_clk) resetn = 0;
		resetn = 1;
		repeat (3) @(negedge ref_clk);
		for (int a = 8'h6e; a < 8'h73; a++) i_host.rd(8'(a), 8'h00);
		for (int i = 0; i < 3; i++) begin
			r = {r[6:0], r[7] ^ r[5] ^ r[4] ^ r[3]};
			d[i] = (r | 8'h80) & 8'hdf;
			{en[i], lp[i]} = {d[i][4], d[i][6] & d[i][4]};
			i_host.wr(8'h6f + 8'(i), d[i]);
			i_host.rd(8'h6f + 8'(i), d[i] & 8'h7f);
		end
		check("setpts", {ldo_four_voltage_setpoint, ldo_five_voltage_setpoint,
			ldo_six_voltage_setpoint}, {d[0][3:0], d[1][3:0], d[2][3:0]});
		check("outs", {ldo_out_lowpwr, ldo_out_on}, {lp, en});
		i_host.wr(8'h6f, 8'h31);
		standby_in = 1;
		repeat (8) @(negedge ref_clk);
		check("stby off", ldo_out_on[0], 1'b0);
		i_host.wr(8'h6f, 8'h71);
		repeat (2) @(negedge ref_clk);
		check("stby low", {ldo_out_lowpwr[0], ldo_out_on[0]}, 2'b11);
		standby_in = 0;
		repeat (8) @(negedge ref_clk);
		check("stby on", {ldo_out_lowpwr[0], ldo_out_on[0]}, 2'b01);
		{scp_enable, short_det} = 4'b1001;
		repeat (8) @(negedge ref_clk);
		check("scp", {ldo_fault_interrupt_flag, ldo_out_on[0], fault_irq}, 5'b00101);
		i_host.rd(8'h6f, 8'h61);
		fault_mask = 3'h7;
		i_host.wr(8'h70, 8'h13);
		{scp_enable, short_det} = 4'b0011;
		repeat (8) @(negedge ref_clk);
		check("no scp", {ldo_fault_interrupt_flag, ldo_out_on[1], fault_irq}, 5'b01110);
		i_host.rd(8'h70, 8'h13);
		short_det = 3'h0;
		repeat (8) @(negedge ref_clk) fault_clr = 3'h3;
		fault_clr = 3'h0;
		@(negedge ref_clk) check("cleared", ldo_fault_interrupt_flag, 3'h0);
		final_report;
	end
endmodule
